/* File: core/fpe_ctrl.sv */
// flash program/erase control registers: mode control, read-only state status,
// two one-hot erase block selects, interrupt status and mask.
// assumes a single-cycle register port and inputs synchronous to I_REF_CLK.
//
// Behaviour
// RQ1: control bit 7 reads write-protect pin level
// RQ2: software write enable permits program and erase
// RQ3: enable low blocks setting any other bit
// RQ4: erase setup bit selects erase setup state
// RQ5: program setup bit selects program setup state
// RQ6: software sets program setup before program go
// RQ7: erase verify bit selects erase verify mode
// RQ8: program verify bit selects program verify mode
// RQ9: erase needs enable and erase setup set
// RQ10: program needs enable and program setup set
// RQ11: software never writes the status register
// RQ12: error flag sets, forcing error protection
// RQ13: reserved status and high-select bits read zero
// RQ14: low block select held zero without enable
// RQ15: several low select bits clear them all
// RQ16: high select held zero, multiple bits clear
// RQ17: low select bits choose blocks seven..zero
// RQ18: high select bits choose two 32k blocks
// RQ19: status writes change nothing, error flag included
//
// The address map and strobed register access were left to the implementer.
`timescale 1ns/10ps
module fpe_ctrl
  import fpe_pkg::*;
(
  // clock and reset
  input wire logic I_REF_CLK,
  input wire logic I_RESETN,
  // register port
  input wire logic [FPE_ADDR_W-1:0] I_ADDR,
  input wire logic [FPE_DATA_W-1:0] I_WDATA,
  input wire logic I_WR,
  input wire logic I_RD,
  output logic [FPE_DATA_W-1:0] O_RDATA,
  // flash side
  input wire logic I_HW_WRITE_PROTECT_LEVEL,
  input wire logic I_FLASH_ERROR,
  output fpe_mode_t O_FLASH_MODE,
  output logic [7:0] O_ERASE_BLOCK_LOW,
  output logic [FPE_EBH_W-1:0] O_ERASE_BLOCK_HIGH,
  // interrupt
  output logic O_IRQ
);

  fpe_state_t st_reg;
  fpe_state_t st_next;
  fpe_ctrl_t wr_ctrl;
  logic [7:0] low_cand;
  logic [FPE_EBH_W-1:0] high_cand;
  logic [FPE_EVT_W-1:0] evt;
  logic wr_mode;
  logic wr_low;
  logic wr_high;
  logic wr_mask;
  logic rd_irq;
  logic busy;

  always_comb begin
    st_next = st_reg;
    wr_ctrl = fpe_ctrl_t'(I_WDATA[6:0]);
    low_cand = 8'h00;
    high_cand = '0;
    evt = '0;
    wr_mode = I_WR && (I_ADDR == FPE_OFS_MODE_CTRL);
    wr_low = I_WR && (I_ADDR == FPE_OFS_EBLK_LOW);
    wr_high = I_WR && (I_ADDR == FPE_OFS_EBLK_HIGH);
    wr_mask = I_WR && (I_ADDR == FPE_OFS_IRQ_MASK);
    rd_irq = I_RD && (I_ADDR == FPE_OFS_IRQ_STAT);
    busy = (st_reg.mode == FPE_MODE_PROGRAM) || (st_reg.mode == FPE_MODE_ERASE);

    // a bit may only go to 1 once the enable already stands; the enable itself
    // must be written first, so one write cannot both unlock and arm
    if (wr_mode) begin
      st_next.ctrl.software_write_enable = wr_ctrl.software_write_enable; // RQ2
      st_next.ctrl.erase_setup = wr_ctrl.erase_setup
        & st_reg.ctrl.software_write_enable; // RQ3 RQ4
      st_next.ctrl.program_setup = wr_ctrl.program_setup
        & st_reg.ctrl.software_write_enable; // RQ3 RQ5
      st_next.ctrl.erase_verify = wr_ctrl.erase_verify
        & st_reg.ctrl.software_write_enable; // RQ3 RQ7
      st_next.ctrl.program_verify = wr_ctrl.program_verify
        & st_reg.ctrl.software_write_enable; // RQ3 RQ8
      st_next.ctrl.erase_go = wr_ctrl.erase_go
        & st_reg.ctrl.software_write_enable; // RQ3
      st_next.ctrl.program_go = wr_ctrl.program_go
        & st_reg.ctrl.software_write_enable; // RQ3
    end

    // each select bit maps to one erase block, low bit to lowest address
    if (wr_low) begin
      low_cand = I_WDATA & {8{st_reg.ctrl.software_write_enable}}; // RQ3 RQ17
      if ((low_cand & 8'(low_cand - 8'h01)) != 8'h00) begin
        st_next.eblk_low = FPE_EBLK_RST; // RQ15
        evt[FPE_EVT_LOW_CLR] = 1'b1;
      end else begin
        st_next.eblk_low = low_cand;
      end
    end

    if (wr_high) begin
      high_cand = I_WDATA[FPE_EBH_W-1:0]
        & {FPE_EBH_W{st_reg.ctrl.software_write_enable}}; // RQ3 RQ18
      if (&high_cand) begin
        st_next.eblk_high = '0; // RQ16
        evt[FPE_EVT_HIGH_CLR] = 1'b1;
      end else begin
        st_next.eblk_high = high_cand;
      end
    end

    // dropping the enable clears everything it guards
    if (!st_next.ctrl.software_write_enable) begin
      st_next.ctrl = fpe_ctrl_t'(FPE_CTRL_RST); // RQ3
      st_next.eblk_low = FPE_EBLK_RST; // RQ14
      st_next.eblk_high = '0; // RQ16
    end

    // error flag is sticky until reset; a status write has no path here
    if (I_FLASH_ERROR && busy && !st_reg.flash_error_flag) begin
      st_next.flash_error_flag = 1'b1; // RQ12 RQ19
      evt[FPE_EVT_ERR] = 1'b1;
    end

    if (st_next.flash_error_flag) begin
      st_next.mode = FPE_MODE_ERROR_PROTECT; // RQ12
    end else if (st_next.ctrl.program_go && st_next.ctrl.program_setup
                 && st_next.ctrl.software_write_enable) begin
      st_next.mode = FPE_MODE_PROGRAM; // RQ10
    end else if (st_next.ctrl.erase_go && st_next.ctrl.erase_setup
                 && st_next.ctrl.software_write_enable) begin
      st_next.mode = FPE_MODE_ERASE; // RQ9
    end else if (st_next.ctrl.program_verify) begin
      st_next.mode = FPE_MODE_PROGRAM_VERIFY; // RQ8
    end else if (st_next.ctrl.erase_verify) begin
      st_next.mode = FPE_MODE_ERASE_VERIFY; // RQ7
    end else if (st_next.ctrl.program_setup) begin
      st_next.mode = FPE_MODE_PROGRAM_SETUP; // RQ5
    end else if (st_next.ctrl.erase_setup) begin
      st_next.mode = FPE_MODE_ERASE_SETUP; // RQ4
    end else begin
      st_next.mode = FPE_MODE_IDLE;
    end

    // read clears, but an event in the same cycle survives
    if (rd_irq) begin
      st_next.irq_stat = FPE_IRQ_RST;
    end
    st_next.irq_stat = st_next.irq_stat | evt;
    if (wr_mask) begin
      st_next.irq_mask = I_WDATA[FPE_EVT_W-1:0];
    end
    st_next.irq = |(st_next.irq_stat & st_next.irq_mask);

    st_next.rdata = FPE_RDATA_RST;
    if (I_RD) begin
      case (I_ADDR)
        FPE_OFS_MODE_CTRL: begin
          st_next.rdata = {I_HW_WRITE_PROTECT_LEVEL, 7'(st_reg.ctrl)}; // RQ1
        end
        FPE_OFS_STATE_STAT: begin
          st_next.rdata = {st_reg.flash_error_flag, 7'h00}; // RQ13
        end
        FPE_OFS_EBLK_LOW: begin
          st_next.rdata = st_reg.eblk_low;
        end
        FPE_OFS_EBLK_HIGH: begin
          st_next.rdata = {6'h00, st_reg.eblk_high}; // RQ13
        end
        FPE_OFS_IRQ_STAT: begin
          st_next.rdata = {5'h00, st_reg.irq_stat};
        end
        FPE_OFS_IRQ_MASK: begin
          st_next.rdata = {5'h00, st_reg.irq_mask};
        end
        default: begin
          st_next.rdata = FPE_RDATA_RST;
        end
      endcase
    end
  end

  always_ff @(posedge I_REF_CLK) begin
    if (!I_RESETN) begin
      st_reg.ctrl <= fpe_ctrl_t'(FPE_CTRL_RST);
      st_reg.flash_error_flag <= 1'b0;
      st_reg.eblk_low <= FPE_EBLK_RST;
      st_reg.eblk_high <= '0;
      st_reg.irq_stat <= FPE_IRQ_RST;
      st_reg.irq_mask <= FPE_IRQ_RST;
      st_reg.rdata <= FPE_RDATA_RST;
      st_reg.irq <= 1'b0;
      st_reg.mode <= FPE_MODE_IDLE;
    end else begin
      st_reg <= st_next;
    end
  end

  assign O_RDATA = st_reg.rdata;
  assign O_FLASH_MODE = st_reg.mode;
  assign O_ERASE_BLOCK_LOW = st_reg.eblk_low;
  assign O_ERASE_BLOCK_HIGH = st_reg.eblk_high;
  assign O_IRQ = st_reg.irq;

  default clocking cb @(posedge I_REF_CLK);
  endclocking
  default disable iff (!I_RESETN);

  chk_wp_readback: assert property ( // RQ1
    I_RD && (I_ADDR == FPE_OFS_MODE_CTRL)
      |=> O_RDATA[FPE_WP_BIT] == $past(I_HW_WRITE_PROTECT_LEVEL))
    else $error("write-protect level not returned in control bit 7");

  chk_enable_guard: assert property ( // RQ3
    !st_reg.ctrl.software_write_enable
      |-> (7'(st_reg.ctrl) == 7'h00) && (st_reg.eblk_low == 8'h00)
          && (st_reg.eblk_high == 2'h0))
    else $error("guarded bit set while enable is low");

  chk_setup_taken: assert property ( // RQ5
    wr_mode && st_reg.ctrl.software_write_enable && I_WDATA[6] && I_WDATA[4]
      |=> st_reg.ctrl.program_setup && O_FLASH_MODE != FPE_MODE_IDLE)
    else $error("program setup write not taken");

  chk_program_cause: assert property ( // RQ10
    O_FLASH_MODE == FPE_MODE_PROGRAM
      |-> st_reg.ctrl.program_go && st_reg.ctrl.program_setup
          && st_reg.ctrl.software_write_enable && !st_reg.flash_error_flag)
    else $error("program mode without its enables");

  chk_erase_cause: assert property ( // RQ9
    O_FLASH_MODE == FPE_MODE_ERASE
      |-> st_reg.ctrl.erase_go && st_reg.ctrl.erase_setup
          && st_reg.ctrl.software_write_enable && !st_reg.flash_error_flag)
    else $error("erase mode without its enables");

  chk_error_sticky: assert property ( // RQ19
    st_reg.flash_error_flag |=> st_reg.flash_error_flag
      && O_FLASH_MODE == FPE_MODE_ERROR_PROTECT)
    else $error("error flag or protection lost");

  chk_error_set: assert property ( // RQ12
    I_FLASH_ERROR && busy |=> st_reg.flash_error_flag ##1 st_reg.irq_stat[FPE_EVT_ERR]
      || $past(rd_irq))
    else $error("flash error not flagged");

  chk_low_onehot: assert property ( // RQ15
    wr_low && st_reg.ctrl.software_write_enable && !$onehot0(I_WDATA)
      |=> O_ERASE_BLOCK_LOW == 8'h00 && st_reg.irq_stat[FPE_EVT_LOW_CLR])
    else $error("multi-bit low select not cleared");

  chk_high_onehot: assert property ( // RQ16
    $onehot0(O_ERASE_BLOCK_HIGH) && $onehot0(O_ERASE_BLOCK_LOW))
    else $error("erase block select not one-hot");

  chk_status_zeros: assert property ( // RQ13
    I_RD && (I_ADDR == FPE_OFS_STATE_STAT || I_ADDR == FPE_OFS_EBLK_HIGH)
      |=> O_RDATA[6:2] == 5'h00)
    else $error("reserved bits read non-zero");

  chk_irq_level: assert property (
    O_IRQ == |(st_reg.irq_stat & st_reg.irq_mask))
    else $error("interrupt output disagrees with status and mask");

  // each mode stands only while the control bits that call for it stand
  chk_enable_taken: assert property ( // RQ2
    wr_mode
      |=> st_reg.ctrl.software_write_enable == $past(I_WDATA[6]))
    else $error("software write enable not taken from write");

  chk_busy_guard: assert property ( // RQ2
    busy
      |-> st_reg.ctrl.software_write_enable)
    else $error("program or erase active without write enable");

  chk_erase_setup: assert property ( // RQ4
    O_FLASH_MODE == FPE_MODE_ERASE_SETUP
      |-> st_reg.ctrl.erase_setup && !st_reg.ctrl.program_setup)
    else $error("erase setup state without its bit");

  chk_program_setup: assert property ( // RQ5
    O_FLASH_MODE == FPE_MODE_PROGRAM_SETUP
      |-> st_reg.ctrl.program_setup && !st_reg.ctrl.erase_verify)
    else $error("program setup state without its bit");

  chk_erase_verify: assert property ( // RQ7
    O_FLASH_MODE == FPE_MODE_ERASE_VERIFY
      |-> st_reg.ctrl.erase_verify && !st_reg.ctrl.program_verify)
    else $error("erase verify mode without its bit");

  chk_program_verify: assert property ( // RQ8
    O_FLASH_MODE == FPE_MODE_PROGRAM_VERIFY
      |-> st_reg.ctrl.program_verify)
    else $error("program verify mode without its bit");

  chk_erase_cancel: assert property ( // RQ9
    wr_mode && !I_WDATA[1]
      |=> O_FLASH_MODE != FPE_MODE_ERASE)
    else $error("erase mode survived clearing its bit");

  chk_program_cancel: assert property ( // RQ10
    wr_mode && !I_WDATA[0]
      |=> O_FLASH_MODE != FPE_MODE_PROGRAM)
    else $error("program mode survived clearing its bit");

  chk_low_cleared: assert property ( // RQ14
    wr_mode && !I_WDATA[6]
      |=> O_ERASE_BLOCK_LOW == 8'h00 && O_ERASE_BLOCK_HIGH == 2'h0)
    else $error("block selects kept after enable cleared");

  chk_low_taken: assert property ( // RQ17
    wr_low && st_reg.ctrl.software_write_enable && $onehot0(I_WDATA)
      |=> O_ERASE_BLOCK_LOW == $past(I_WDATA))
    else $error("single low block select not stored");

  chk_low_readback: assert property ( // RQ17
    I_RD && (I_ADDR == FPE_OFS_EBLK_LOW)
      |=> O_RDATA == $past(O_ERASE_BLOCK_LOW))
    else $error("low block select read back wrong");

  chk_high_taken: assert property ( // RQ18
    wr_high && st_reg.ctrl.software_write_enable && !(&I_WDATA[FPE_EBH_W-1:0])
      |=> O_ERASE_BLOCK_HIGH == $past(I_WDATA[FPE_EBH_W-1:0]))
    else $error("single high block select not stored");

  chk_high_guard: assert property ( // RQ16
    wr_high && st_reg.ctrl.software_write_enable && (&I_WDATA[FPE_EBH_W-1:0])
      |=> O_ERASE_BLOCK_HIGH == 2'h0 && st_reg.irq_stat[FPE_EVT_HIGH_CLR])
    else $error("multi-bit high select not cleared");

  chk_error_only_busy: assert property ( // RQ12
    !st_reg.flash_error_flag && !(I_FLASH_ERROR && busy)
      |=> !st_reg.flash_error_flag)
    else $error("error flag set without an error in program or erase");

  chk_status_write: assert property ( // RQ19
    I_WR && (I_ADDR == FPE_OFS_STATE_STAT)
      |=> st_reg.flash_error_flag == $past(st_reg.flash_error_flag)
          || $past(I_FLASH_ERROR && busy))
    else $error("status write changed the error flag");

  chk_rdata_idle: assert property (
    !I_RD
      |=> O_RDATA == FPE_RDATA_RST)
    else $error("read data not zero outside a read");

  chk_ctrl_readback: assert property ( // RQ2
    I_RD && (I_ADDR == FPE_OFS_MODE_CTRL)
      |=> O_RDATA[6:0] == $past(7'(st_reg.ctrl)))
    else $error("control bits read back wrong");

  chk_unmapped_read: assert property (
    I_RD && (I_ADDR > FPE_OFS_IRQ_MASK)
      |=> O_RDATA == FPE_RDATA_RST)
    else $error("unmapped read returned non-zero");

  chk_irq_clear: assert property (
    rd_irq && (evt == FPE_IRQ_RST)
      |=> st_reg.irq_stat == FPE_IRQ_RST)
    else $error("interrupt status not cleared by its read");

  chk_irq_kept: assert property (
    (evt != FPE_IRQ_RST)
      |=> (st_reg.irq_stat & $past(evt)) == $past(evt))
    else $error("interrupt event lost");

  chk_mask_taken: assert property (
    wr_mask
      |=> st_reg.irq_mask == $past(I_WDATA[FPE_EVT_W-1:0]))
    else $error("interrupt mask write not taken");

endmodule

/* File: dv/fpe_ctrl_tb.sv */
// self-checking bench for the flash program/erase control registers.
// assumes the single-cycle register port and the register map of fpe_pkg.
`timescale 1ns/10ps
module fpe_ctrl_tb;
  import fpe_pkg::*;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic rd_q = 1'b0;
  logic wp = 1'b0;
  logic ferr = 1'b0;
  logic [FPE_ADDR_W-1:0] addr = 4'h0;
  logic [FPE_DATA_W-1:0] wdata = 8'h00;
  logic [7:0] rdata;
  logic [7:0] eb_low;
  logic [1:0] eb_high;
  fpe_mode_t mode;
  logic irq;
  logic [7:0] exp_q[$];
  int num_errors = 0;
  int tests_run = 0;
  int cycles = 0;
  int seed;
  logic [7:0] mw [10] = '{8'h60, 8'h50, 8'h48, 8'h44, 8'h42, 8'h62, 8'h60, 8'h50, 8'h51, 8'h41};
  fpe_mode_t mm [10] = '{FPE_MODE_ERASE_SETUP, FPE_MODE_PROGRAM_SETUP, FPE_MODE_ERASE_VERIFY,
    FPE_MODE_PROGRAM_VERIFY, FPE_MODE_IDLE, FPE_MODE_ERASE, FPE_MODE_ERASE_SETUP,
    FPE_MODE_PROGRAM_SETUP, FPE_MODE_PROGRAM, FPE_MODE_IDLE};

  always #10 clk = ~clk;

  fpe_ctrl dut (
    .I_REF_CLK(clk),
    .I_RESETN(rstn),
    .I_ADDR(addr),
    .I_WDATA(wdata),
    .I_WR(wr),
    .I_RD(rd),
    .O_RDATA(rdata),
    .I_HW_WRITE_PROTECT_LEVEL(wp),
    .I_FLASH_ERROR(ferr),
    .O_FLASH_MODE(mode),
    .O_ERASE_BLOCK_LOW(eb_low),
    .O_ERASE_BLOCK_HIGH(eb_high),
    .O_IRQ(irq)
  );

  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      num_errors++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic complete_run();
    $display("checks %0d mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  // the gap cycle before each strobe keeps a strobe from being assigned twice at one edge
  task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  task automatic rd_reg(input logic [3:0] a, input logic [7:0] exp);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    exp_q.push_back(exp);
    @(posedge clk);
    rd <= 1'b0;
  endtask

  // read data stand only in the cycle after the strobe
  always @(posedge clk) rd_q <= rd;
  always @(negedge clk) begin
    if (rd_q) check("read data", rdata, exp_q.pop_front());
  end

  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      num_errors++;
      complete_run();
    end
  end

  initial begin
    seed = $urandom(32'hc14afb64);
    repeat (3) @(posedge clk);
    rstn <= 1'b1;
    wp <= 1'($urandom_range(1, 0));
    @(posedge clk);
    for (int a = 0; a < 6; a++) rd_reg(4'(a), (a == 0) ? {wp, 7'h00} : 8'h00);
    // guarded bits cannot be set while enable is still clear
    wr_reg(FPE_OFS_EBLK_LOW, 8'h01);
    wr_reg(FPE_OFS_EBLK_HIGH, 8'h01);
    wr_reg(FPE_OFS_MODE_CTRL, 8'h7F);
    rd_reg(FPE_OFS_MODE_CTRL, {wp, 7'h40});
    rd_reg(FPE_OFS_EBLK_LOW, 8'h00);
    rd_reg(FPE_OFS_EBLK_HIGH, 8'h00);
    // program setup precedes program go in this table, save the last entry, which writes go without setup and expects idle
    for (int i = 0; i < 10; i++) begin
      @(posedge clk) wp <= 1'($urandom_range(1, 0));
      wr_reg(FPE_OFS_MODE_CTRL, mw[i]);
      @(negedge clk);
      check("mode", {5'h00, mode}, {5'h00, mm[i]});
      rd_reg(FPE_OFS_MODE_CTRL, {wp, mw[i][6:0]});
    end
    for (int k = 0; k < 8; k++) begin
      wr_reg(FPE_OFS_EBLK_LOW, 8'h01 << k);
      @(negedge clk);
      check("select low", eb_low, 8'h01 << k);
      rd_reg(FPE_OFS_EBLK_LOW, 8'h01 << k);
    end
    wr_reg(FPE_OFS_EBLK_LOW, 8'h03);
    rd_reg(FPE_OFS_EBLK_LOW, 8'h00);
    wr_reg(FPE_OFS_EBLK_HIGH, 8'hFE);
    @(negedge clk);
    check("select high", {6'h00, eb_high}, 8'h02);
    rd_reg(FPE_OFS_EBLK_HIGH, 8'h02);
    wr_reg(FPE_OFS_EBLK_HIGH, 8'h03);
    rd_reg(FPE_OFS_EBLK_HIGH, 8'h00);
    wr_reg(FPE_OFS_EBLK_LOW, 8'h10);
    wr_reg(FPE_OFS_IRQ_MASK, 8'h07);
    @(negedge clk);
    check("irq raised", {7'h00, irq}, 8'h01);
    rd_reg(FPE_OFS_IRQ_STAT, 8'h06);
    @(negedge clk);
    check("irq cleared", {7'h00, irq}, 8'h00);
    // clearing the enable drops the selects in the same edge
    wr_reg(FPE_OFS_MODE_CTRL, 8'h00);
    @(negedge clk);
    check("select low", eb_low, 8'h00);
    check("mode", {5'h00, mode}, {5'h00, FPE_MODE_IDLE});
    wr_reg(FPE_OFS_EBLK_LOW, 8'h04);
    rd_reg(FPE_OFS_EBLK_LOW, 8'h00);
    // status writes are misuse on purpose: the flag must shrug them off
    wr_reg(FPE_OFS_STATE_STAT, 8'h80);
    rd_reg(FPE_OFS_STATE_STAT, 8'h00);
    wr_reg(4'hF, 8'hFF);
    rd_reg(4'hF, 8'h00);
    wr_reg(FPE_OFS_MODE_CTRL, 8'h40);
    wr_reg(FPE_OFS_MODE_CTRL, 8'h50);
    wr_reg(FPE_OFS_MODE_CTRL, 8'h51);
    @(posedge clk) ferr <= 1'b1;
    @(posedge clk) ferr <= 1'b0;
    repeat (2) @(negedge clk);
    check("mode", {5'h00, mode}, {5'h00, FPE_MODE_ERROR_PROTECT});
    check("irq error", {7'h00, irq}, 8'h01);
    rd_reg(FPE_OFS_STATE_STAT, 8'h80);
    wr_reg(FPE_OFS_STATE_STAT, 8'h00);
    rd_reg(FPE_OFS_STATE_STAT, 8'h80);
    rd_reg(FPE_OFS_IRQ_STAT, 8'h01);
    repeat (3) @(posedge clk);
    complete_run();
  end
endmodule

/* File: include/fpe_pkg.sv */
// package for the flash program/erase control block: register map, field layout,
// reset values, mode encoding and the state carrier.
// assumes a byte-wide register port with a 4-bit address.
package fpe_pkg;

  localparam int unsigned FPE_ADDR_W = 4;
  localparam int unsigned FPE_DATA_W = 8;
  localparam int unsigned FPE_EVT_W = 3;

  // register offsets
  localparam logic [FPE_ADDR_W-1:0] FPE_OFS_MODE_CTRL = 4'h0;
  localparam logic [FPE_ADDR_W-1:0] FPE_OFS_STATE_STAT = 4'h1;
  localparam logic [FPE_ADDR_W-1:0] FPE_OFS_EBLK_LOW = 4'h2;
  localparam logic [FPE_ADDR_W-1:0] FPE_OFS_EBLK_HIGH = 4'h3;
  localparam logic [FPE_ADDR_W-1:0] FPE_OFS_IRQ_STAT = 4'h4;
  localparam logic [FPE_ADDR_W-1:0] FPE_OFS_IRQ_MASK = 4'h5;

  // field positions
  localparam int unsigned FPE_WP_BIT = 7;
  localparam int unsigned FPE_ERR_BIT = 7;
  localparam int unsigned FPE_EBH_W = 2;
  localparam int unsigned FPE_EVT_ERR = 0;
  localparam int unsigned FPE_EVT_LOW_CLR = 1;
  localparam int unsigned FPE_EVT_HIGH_CLR = 2;

  // reset values
  localparam logic [6:0] FPE_CTRL_RST = 7'h00;
  localparam logic [7:0] FPE_EBLK_RST = 8'h00;
  localparam logic [7:0] FPE_RDATA_RST = 8'h00;
  localparam logic [FPE_EVT_W-1:0] FPE_IRQ_RST = 3'h0;

  // writable part of the mode control register, bit 6 down to bit 0
  typedef struct packed {
    logic software_write_enable;
    logic erase_setup;
    logic program_setup;
    logic erase_verify;
    logic program_verify;
    logic erase_go;
    logic program_go;
  } fpe_ctrl_t;

  typedef enum logic [2:0] {
    FPE_MODE_IDLE,
    FPE_MODE_ERASE_SETUP,
    FPE_MODE_PROGRAM_SETUP,
    FPE_MODE_ERASE_VERIFY,
    FPE_MODE_PROGRAM_VERIFY,
    FPE_MODE_ERASE,
    FPE_MODE_PROGRAM,
    FPE_MODE_ERROR_PROTECT
  } fpe_mode_t;

  typedef struct packed {
    fpe_ctrl_t ctrl;
    logic flash_error_flag;
    logic [7:0] eblk_low;
    logic [FPE_EBH_W-1:0] eblk_high;
    logic [FPE_EVT_W-1:0] irq_stat;
    logic [FPE_EVT_W-1:0] irq_mask;
    logic [FPE_DATA_W-1:0] rdata;
    logic irq;
    fpe_mode_t mode;
  } fpe_state_t;

endpackage
